// ==== common/css_pkg.sv ====
/*
 * Shared constants and types of the clocked serial slave sequencer.
 * Assumes nothing beyond a SystemVerilog compiler; css_sequencer and tb_top name it explicitly.
 */
package css_pkg;
    localparam int BYTE_W = 8;
    localparam logic [7:0] DUMMY_BYTE = 8'hFF;
    localparam logic [7:0] BUF_RESET = 8'hFF;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int SYNC_STAGES = 2;

    // which handler serves the next channel event
    typedef enum logic [2:0] {
        HND_IDLE = 3'b000,
        HND_TXRX_FIRST = 3'b001,
        HND_TXRX_LATER = 3'b010,
        HND_LAST_RX = 3'b011,
        HND_XFER_START = 3'b100
    } css_handler_type;

    // channel operating mode
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_TX = 2'b01,
        MODE_RX = 2'b10,
        MODE_TXRX = 2'b11
    } css_mode_type;
endpackage

// ==== rtl/css_sync.sv ====
/*
 * Two-flop synchroniser for a group of single-bit pin inputs.
 * Assumes the inputs are asynchronous to core_clk; reset value is a parameter.
 */
module css_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // elaboration-time refusal of a width the flops cannot serve
    if (WIDTH < 1) begin : g_width_check
        $error("css_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ==== rtl/css_sequencer.sv ====
/*
 * Serial slave channel with its character sequencer: shift engine driven by an
 * external master (chip select, clock, data in), shift buffer, remaining count,
 * busy handshake and event-handler selection.
 * Assumes mode-0 framing (sample on rising link clock, change on falling), link
 * clock well below core_clk/4, and a user that presents the next transmit byte
 * before the channel asks for it.
 */
// How it works
// - On the first buffer-empty event of continuous transfer, load the next transmit byte unless the count is 1.
// - With the count at 1, raise busy, switch event timing to transfer end and expect the last-byte completion next.
// - On later buffer-empty events, store the received byte, decrement the count, then treat it like the first event.
// - A single-character send sets transmit mode, loads the byte, sets the count to 1 and awaits the transfer-start event.
// - A single-character receive does the same with an all-ones dummy byte.
// - A single-character send is refused unless the channel is configured for transmit or transmit/receive.
// - The last-byte completion event stores the final received byte and clears the count to zero.
// - A zero count means the transfer is finished and the received byte can be read.
module css_sequencer #(
    parameter int CNT_W = 8
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // link pins
    input wire logic link_sck,
    input wire logic link_cs_n,
    input wire logic link_mosi,
    output logic link_miso,
    output logic link_miso_oe_n,
    output logic busy,
    // user commands
    input wire logic [1:0] chan_cfg,
    input wire logic start_txrx,
    input wire logic [CNT_W-1:0] start_count,
    input wire logic start_tx1,
    input wire logic start_rx1,
    input wire logic [7:0] tx_data,
    output logic tx_take,
    // user results
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [CNT_W-1:0] remaining_char_count,
    output logic [1:0] chan_mode
);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // elaboration-time refusal of a count too narrow for the last-byte test
    if (CNT_W < 2) begin : g_cnt_check
        $error("css_sequencer: CNT_W must be at least 2");
    end

    logic sck_s;
    logic cs_n_s;
    logic mosi_s;
    logic sck_d_reg;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] serial_shift_buffer;
    logic [7:0] shreg;
    logic [7:0] rx_hold_reg;
    logic [2:0] bit_cnt;
    logic need_load_reg;
    logic ev_empty;
    logic ev_end;
    logic timing_end_reg;
    logic channel_event;
    logic idle_ok;
    logic [7:0] rx_now;
    logic [CNT_W-1:0] cnt_after;
    css_pkg::css_handler_type next_event_handler_select;

    css_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h2)
    ) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .ce(ce),
        .async_in({link_sck, link_cs_n, link_mosi}),
        .sync_out({sck_s, cs_n_s, mosi_s})
    );

    // link clock edge finder
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sck_d_reg <= 1'b0;
        end else if (ce) begin
            sck_d_reg <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
    // buffer empties when the shift register takes its byte
    assign ev_empty = ~cs_n_s & need_load_reg & ~sck_rise;
    assign ev_end = sck_rise & (bit_cnt == css_pkg::BIT_LAST);
    assign rx_now = {shreg[6:0], mosi_s};
    assign channel_event = timing_end_reg ? ev_end : ev_empty;
    assign idle_ok = (remaining_char_count == CNT_ZERO);
    assign cnt_after = remaining_char_count - CNT_ONE;

    // shift engine
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shreg <= css_pkg::BUF_RESET;
            bit_cnt <= css_pkg::BIT_FIRST;
            need_load_reg <= 1'b1;
            rx_hold_reg <= '0;
            link_miso <= 1'b1;
            link_miso_oe_n <= 1'b1;
        end else if (ce) begin
            link_miso_oe_n <= cs_n_s;
            if (cs_n_s) begin
                bit_cnt <= css_pkg::BIT_FIRST;
                need_load_reg <= 1'b1;
            end else if (sck_rise) begin
                shreg <= rx_now;
                bit_cnt <= bit_cnt + 3'h1;
                if (ev_end) begin
                    rx_hold_reg <= rx_now;
                    need_load_reg <= 1'b1;
                end
            end else if (ev_empty) begin
                shreg <= serial_shift_buffer;
                link_miso <= serial_shift_buffer[7];
                need_load_reg <= 1'b0;
            end else if (sck_fall) begin
                link_miso <= shreg[7];
            end
        end
    end

    // sequencer: commands and event handlers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_shift_buffer <= css_pkg::BUF_RESET;
            remaining_char_count <= CNT_ZERO;
            next_event_handler_select <= css_pkg::HND_IDLE;
            timing_end_reg <= 1'b0;
            busy <= 1'b0;
            tx_take <= 1'b0;
            rx_data <= '0;
            rx_valid <= 1'b0;
            chan_mode <= css_pkg::MODE_OFF;
        end else if (ce) begin
            tx_take <= 1'b0;
            rx_valid <= 1'b0;
            if (idle_ok && start_txrx && start_count != CNT_ZERO) begin
                chan_mode <= css_pkg::MODE_TXRX;
                serial_shift_buffer <= tx_data;
                tx_take <= 1'b1;
                remaining_char_count <= start_count;
                next_event_handler_select <= css_pkg::HND_TXRX_FIRST;
                timing_end_reg <= 1'b0;
                busy <= 1'b0;
            end else if (idle_ok && start_tx1
                         && (chan_cfg == css_pkg::MODE_TX
                             || chan_cfg == css_pkg::MODE_TXRX)) begin
                chan_mode <= css_pkg::MODE_TX;
                serial_shift_buffer <= tx_data;
                tx_take <= 1'b1;
                remaining_char_count <= CNT_ONE;
                next_event_handler_select <= css_pkg::HND_XFER_START;
                timing_end_reg <= 1'b0;
                busy <= 1'b0;
            end else if (idle_ok && start_rx1) begin
                chan_mode <= css_pkg::MODE_TX;
                serial_shift_buffer <= css_pkg::DUMMY_BYTE;
                remaining_char_count <= CNT_ONE;
                next_event_handler_select <= css_pkg::HND_XFER_START;
                timing_end_reg <= 1'b0;
                busy <= 1'b0;
            end else if (channel_event) begin
                unique case (next_event_handler_select)
                    css_pkg::HND_IDLE: begin
                    end
                    css_pkg::HND_TXRX_FIRST: begin
                        if (remaining_char_count != CNT_ONE) begin
                            serial_shift_buffer <= tx_data;
                            tx_take <= 1'b1;
                            next_event_handler_select <= css_pkg::HND_TXRX_LATER;
                        end else begin
                            busy <= 1'b1;
                            timing_end_reg <= 1'b1;
                            next_event_handler_select <= css_pkg::HND_LAST_RX;
                        end
                    end
                    css_pkg::HND_TXRX_LATER: begin
                        rx_data <= rx_hold_reg;
                        rx_valid <= 1'b1;
                        remaining_char_count <= cnt_after;
                        if (cnt_after != CNT_ONE) begin
                            serial_shift_buffer <= tx_data;
                            tx_take <= 1'b1;
                        end else begin
                            busy <= 1'b1;
                            timing_end_reg <= 1'b1;
                            next_event_handler_select <= css_pkg::HND_LAST_RX;
                        end
                    end
                    css_pkg::HND_XFER_START: begin
                        busy <= 1'b1;
                        timing_end_reg <= 1'b1;
                        next_event_handler_select <= css_pkg::HND_LAST_RX;
                    end
                    css_pkg::HND_LAST_RX: begin
                        rx_data <= rx_now;
                        rx_valid <= 1'b1;
                        remaining_char_count <= CNT_ZERO;
                        timing_end_reg <= 1'b0;
                        next_event_handler_select <= css_pkg::HND_IDLE;
                    end
                    default: begin
                        next_event_handler_select <= css_pkg::HND_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ==== test/css_seq_asserts.sv ====
/*
 * Timing checks on the sequencer's command and result ports.
 * Assumes binding to css_sequencer; one clock domain.
 */
module css_seq_asserts #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // commands
    input wire logic [1:0] chan_cfg,
    input wire logic start_txrx,
    input wire logic [CNT_W-1:0] start_count,
    input wire logic start_tx1,
    input wire logic start_rx1,
    // results
    input wire logic busy,
    input wire logic tx_take,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic [CNT_W-1:0] remaining_char_count,
    input wire logic [1:0] chan_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    wire [CNT_W-1:0] cnt = remaining_char_count;
    wire idle_ok = ce && cnt == '0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_accept;
        cnt == '0 ##1 cnt != '0;
    endsequence
    property p_txrx;
        idle_ok && start_txrx && start_count != '0 |=> cnt == $past(start_count) && tx_take;
    endproperty
    a_txrx: assert property (p_txrx) else $error("continuous start not taken");
    property p_tx1;
        idle_ok && start_tx1 && !start_txrx && chan_cfg[0] |=> cnt == 1 && tx_take && chan_mode == 2'h1;
    endproperty
    a_tx1: assert property (p_tx1) else $error("single send not taken");
    property p_rx1;
        idle_ok && start_rx1 && !start_txrx && !start_tx1 |=> cnt == 1 && !tx_take && chan_mode == 2'h1;
    endproperty
    a_rx1: assert property (p_rx1) else $error("single receive not taken");
    property p_refuse;
        idle_ok && start_tx1 && !chan_cfg[0] && !start_txrx && !start_rx1 |=> cnt == '0 && !tx_take;
    endproperty
    a_refuse: assert property (p_refuse) else $error("send accepted in bad mode");
    property p_step;
        $past(cnt) != '0 && cnt != $past(cnt) |-> rx_valid && cnt == $past(cnt) - 1;
    endproperty
    a_step: assert property (p_step) else $error("count step wrong");
    property p_busy_rise;
        $rose(busy) |-> cnt == 1;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy raised early");
    property p_busy_clear;
        s_accept |-> !busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy kept on start");
    property p_last;
        $past(cnt) == 1 && cnt == '0 |-> rx_valid && busy;
    endproperty
    a_last: assert property (p_last) else $error("last byte not stored");
    property p_hold;
        cnt == '0 && $past(cnt) == '0 |-> !rx_valid && $stable(rx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved while idle");
endmodule

// ==== test/css_master_model.sv ====
/*
 * Serial master: chip select, mode-0 clock, data out msb first.
 * Assumes the bench fills mq before frame and reads sq after it.
 */
module css_master_model (
    // link pins
    output logic link_sck,
    output logic link_cs_n,
    output logic link_mosi,
    input wire logic link_miso,
    input wire logic link_miso_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mq[$];
    logic [7:0] sq[$];
    // counts sampling edges at which the slave was not driving its data line
    int oe_err;
    initial begin
        oe_err = 0;
        link_sck = 1'b0;
        link_cs_n = 1'b1;
        link_mosi = 1'b0;
    end
    task automatic frame(input int n);
        logic [7:0] t;
        logic [7:0] r;
        link_cs_n = 1'b0;
        #100;
        repeat (n) begin
            t = mq.pop_front();
            for (int i = 7; i >= 0; i--) begin
                link_mosi = t[i];
                #40 link_sck = 1'b1;
                r[i] = link_miso;
                if (link_miso_oe_n !== 1'b0) oe_err++;
                #40 link_sck = 1'b0;
            end
            sq.push_back(r);
            #40;
        end
        link_cs_n = 1'b1;
        // released line: no stale value
        link_mosi = ~link_mosi;
    endtask
endmodule

// ==== test/tb_top.sv ====
/*
 * Self-checking bench: random continuous and single transfers.
 * Assumes css_sequencer and the master model; core_clk 200 MHz.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, nrst, ce, start_txrx, start_tx1, start_rx1, tx_take, rx_valid, busy;
    logic link_sck, link_cs_n, link_mosi, link_miso, link_miso_oe_n;
    logic [1:0] chan_cfg, chan_mode;
    logic [7:0] start_count, tx_data, rx_data, remaining_char_count;
    logic [7:0] txv[$], rxv[$], mv[$];
    int mismatches, cmp_count;
    css_sequencer u_css_sequencer(.core_clk, .nrst, .ce, .link_sck, .link_cs_n, .link_mosi,
        .link_miso, .link_miso_oe_n, .busy, .chan_cfg, .start_txrx, .start_count, .start_tx1,
        .start_rx1, .tx_data, .tx_take, .rx_data, .rx_valid, .remaining_char_count, .chan_mode);
    css_master_model u_css_master_model(.link_sck, .link_cs_n, .link_mosi, .link_miso,
        .link_miso_oe_n);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function logic [7:0] exp_out(input int kind, input int i);
        return (kind == 2) ? css_pkg::DUMMY_BYTE : txv[i];
    endfunction
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // next byte ready before the channel asks again
    always @(negedge core_clk) begin
        if (tx_take) begin
            txv.push_back(tx_data);
            tx_data <= $urandom;
        end
        if (rx_valid) rxv.push_back(rx_data);
    end
    task run(input int kind, input int n, input logic [1:0] cfg);
        int i;
        txv.delete();
        rxv.delete();
        mv.delete();
        for (i = 0; i < n; i++) mv.push_back($urandom);
        u_css_master_model.mq = mv;
        @(negedge core_clk);
        chan_cfg = cfg;
        start_count = 8'(n);
        start_txrx = (kind == 0);
        start_tx1 = (kind == 1);
        start_rx1 = (kind == 2);
        @(negedge core_clk);
        // a start while a transfer is open must be ignored
        {start_txrx, start_tx1, start_rx1} = {2'h0, remaining_char_count != 8'h00};
        if (kind == 1 && !cfg[0]) begin
            repeat (3) @(negedge core_clk);
            check(remaining_char_count, 8'h00);
            check(8'(txv.size()), 8'h00);
            return;
        end
        @(negedge core_clk);
        start_rx1 = 1'b0;
        u_css_master_model.frame(n);
        i = 0;
        while (remaining_char_count !== 8'h00 && i < 200) begin
            @(negedge core_clk);
            i++;
        end
        repeat (4) @(negedge core_clk);
        check(remaining_char_count, 8'h00);
        check({7'h00, link_miso_oe_n}, 8'h01);
        check(8'(u_css_master_model.oe_err), 8'h00);
        check(8'(txv.size()), (kind == 2) ? 8'h00 : 8'(n));
        check(8'(rxv.size()), 8'(n));
        for (i = 0; i < n; i++) begin
            check(u_css_master_model.sq[i], exp_out(kind, i));
            check(rxv[i], mv[i]);
        end
        u_css_master_model.sq.delete();
    endtask
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        chan_cfg = 2'h3;
        {start_txrx, start_tx1, start_rx1} = 3'h0;
        start_count = 8'h00;
        mismatches = 0;
        cmp_count = 0;
        void'($urandom(50));
        tx_data = $urandom;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        run(0, 1, 2'h3);
        run(0, 2, 2'h3);
        run(0, 0, 2'h3);
        run(1, 1, 2'h1);
        run(2, 1, 2'h2);
        run(1, 1, 2'h2);
        run(1, 1, 2'h0);
        run(1, 1, 2'h3);
        // a frozen block ignores its commands
        ce = 1'b0;
        start_rx1 = 1'b1;
        repeat (3) @(negedge core_clk);
        start_rx1 = 1'b0;
        ce = 1'b1;
        check(remaining_char_count, 8'h00);
        run(2, 1, 2'h3);
        repeat (6) run($urandom % 3, 1, 2'h3);
        repeat (6) run(0, 1 + $urandom % 6, 2'h3);
        test_done;
    end
    initial begin
        #150000;
        mismatches++;
        test_done;
    end
endmodule
bind css_sequencer css_seq_asserts #(.CNT_W(CNT_W)) u_css_seq_asserts(.core_clk, .nrst, .ce,
    .chan_cfg, .start_txrx, .start_count, .start_tx1, .start_rx1, .busy, .tx_take, .rx_data,
    .rx_valid, .remaining_char_count, .chan_mode);
